// file: common/tarc_cfg.svh
`ifndef TARC_CFG_SVH
`define TARC_CFG_SVH

// register indices; byte address is four times the index
`define TARC_IDX_COARSE 8'h8c
`define TARC_IDX_FINE 8'h8d
`define TARC_IDX_MONITOR 8'h8e
`define TARC_IDX_CONV_SEL 8'h8f
`define TARC_IDX_OFFSET 8'h90
`define TARC_IDX_SLOPE 8'h91
`define TARC_IDX_RATE_POS 8'h92
`define TARC_IDX_CLK_REC 8'ha0

// reset values
`define TARC_RST_COARSE 5'h10
`define TARC_RST_FINE 4'h0
`define TARC_RST_MONITOR 1'h1
`define TARC_RST_CONV_SEL 3'h0
`define TARC_RST_OFFSET 8'h80
`define TARC_RST_SLOPE 8'h80
`define TARC_RST_RATE_POS 8'h1e
`define TARC_RST_CLK_REC 1'h0

// field limits and positions
`define TARC_COARSE_MAX 5'h18
`define TARC_SLOPE_SHIFT 7
`define TARC_MON_EN_BIT 0
`define TARC_LIMIT_EN_BIT 0

// bus answers
`define TARC_RESP_OKAY 2'h0
`define TARC_RESP_SLVERR 2'h2

`endif

// file: common/tarc_pkg.sv
package tarc_pkg;

    // strength correction settings, offset code and slope code
    typedef struct packed {
        logic [7:0] offset;
        logic [7:0] slope;
    } tarc_corr_s;

    // crystal trim outputs
    typedef struct packed {
        logic [4:0] coarse;
        logic [3:0] fine;
    } tarc_trim_s;

    // corrected strength sample
    typedef logic signed [10:0] tarc_strength_t;

endpackage

// file: hw/tarc_strength_corr.sv
`timescale 1ns/10ps
`default_nettype none
`include "tarc_cfg.svh"

module tarc_strength_corr
    import tarc_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // settings and raw sample
    input wire tarc_corr_s corr,
    input wire logic [7:0] raw,
    input wire logic raw_valid,
    // corrected sample
    output tarc_strength_t value,
    output logic value_valid
);

    // ------------------------------------------------
    // datapath
    // ------------------------------------------------
    logic [15:0] product; // raw times slope code
    logic [8:0] scaled; // product times 2^-7
    logic signed [10:0] offs; // offset code mapped to steps of two

    assign product = {8'h00, raw} * {8'h00, corr.slope};
    assign scaled = product[15:`TARC_SLOPE_SHIFT];
    // code 00h gives -256, 80h gives zero, ffh gives 254
    assign offs = $signed({2'h0, corr.offset, 1'h0}) - 11'sh100;

    // registered result keeps the output path short
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            value <= '0;
            value_valid <= 1'h0;
        end else begin
            value_valid <= raw_valid;
            if (raw_valid) begin
                value <= $signed({2'h0, scaled}) + offs;
            end
        end
    end

endmodule
`default_nettype wire

// file: hw/tarc_rate_check.sv
`timescale 1ns/10ps
`default_nettype none

module tarc_rate_check (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // settings
    input wire logic limit_en,
    input wire logic [7:0] threshold,
    // measured deviation above nominal
    input wire logic [7:0] deviation,
    input wire logic dev_valid,
    // verdict
    output logic accept,
    output logic accept_valid
);

    // ------------------------------------------------
    // acceptance decision
    // ------------------------------------------------
    // with the limit off every rate passes and the threshold is ignored
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            accept <= 1'h1;
            accept_valid <= 1'h0;
        end else begin
            accept_valid <= dev_valid;
            if (dev_valid) begin
                accept <= !limit_en || (deviation <= threshold);
            end
        end
    end

endmodule
`default_nettype wire

// file: hw/tarc_regs.sv
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "tarc_cfg.svh"

// Notes on behaviour
// - coarse trim 5 bits, 1 pF per step
// - coarse codes above 18h act as 24 pF
// - four fine trim bits, reset disconnected
// - monitor bit 0 enables strength pin buffer
// - 3-bit converter input select, reset 000
// - offset code maps -256..254 in steps two
// - slope multiplies by code times 2^-7
// - positive rate threshold sets accepted deviation
// - rate check active only with limit enable
module tarc_regs
    import tarc_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [9:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [9:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // trim and analogue controls
    output tarc_trim_s trim,
    output logic strength_pin_buffer_enable,
    output logic [2:0] converter_input_select,
    // raw signal strength in, corrected out
    input wire logic [7:0] signal_strength,
    input wire logic signal_strength_valid,
    output tarc_strength_t strength_corrected,
    output logic strength_corrected_valid,
    // recovered rate check
    input wire logic [7:0] rate_deviation,
    input wire logic rate_deviation_valid,
    output logic rate_accept,
    output logic rate_accept_valid
);

    // ------------------------------------------------
    // register storage
    // ------------------------------------------------
    // only the documented field bits are stored, so the
    // unused upper bits cannot hold anything
    logic [4:0] coarse_load_cap_code; // raw coarse code as written
    logic [3:0] crystal_fine_trim; // fine capacitor switches
    logic monitor_en; // strength pin buffer enable bit
    logic [2:0] conv_sel; // converter input selector
    logic [7:0] strength_offset_comp; // offset code
    logic [7:0] strength_slope_comp; // slope code
    logic [7:0] rate_accept_pos_threshold; // positive threshold
    logic rate_limit_enable; // clock recovery limit enable

    // ------------------------------------------------
    // write channel state
    // ------------------------------------------------
    logic aw_held; // write address captured
    logic w_held; // write data captured
    logic [7:0] aw_idx; // captured register index
    logic [7:0] w_byte; // captured low data byte
    logic w_lane0; // captured strobe of the low lane
    logic do_write; // both halves present this cycle
    logic wr_hit; // captured index is mapped

    // ------------------------------------------------
    // read channel state
    // ------------------------------------------------
    logic [7:0] ar_idx; // index of the incoming read
    logic [7:0] next_rbyte; // decoded read value
    logic rd_hit; // read index is mapped
    logic ar_take; // read address handshake

    // index from a byte address; low two bits do not select
    assign ar_idx = s_axi_araddr[9:2];
    assign ar_take = s_axi_arvalid && s_axi_arready;

    // the write happens once both halves are held and the
    // previous response has gone
    assign do_write = aw_held && w_held && !s_axi_bvalid;

    // ------------------------------------------------
    // address decode
    // ------------------------------------------------
    // one lookup serves both directions
    function automatic logic idx_mapped(input logic [7:0] idx);
        logic hit;
        hit = 1'h0;
        unique case (idx)
            `TARC_IDX_COARSE,
            `TARC_IDX_FINE,
            `TARC_IDX_MONITOR,
            `TARC_IDX_CONV_SEL,
            `TARC_IDX_OFFSET,
            `TARC_IDX_SLOPE,
            `TARC_IDX_RATE_POS,
            `TARC_IDX_CLK_REC: begin
                hit = 1'h1;
            end
            default: begin
                hit = 1'h0;
            end
        endcase
        return hit;
    endfunction

    assign wr_hit = idx_mapped(aw_idx);
    assign rd_hit = idx_mapped(ar_idx);

    // ------------------------------------------------
    // write address capture
    // ------------------------------------------------
    // ready drops while an address is held so that the
    // master keeps the next one until this write is done
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'h0;
            aw_idx <= 8'h00;
            s_axi_awready <= 1'h0;
        end else begin
            if (do_write) begin
                aw_held <= 1'h0;
                s_axi_awready <= 1'h1;
            end else if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'h1;
                aw_idx <= s_axi_awaddr[9:2];
                s_axi_awready <= 1'h0;
            end else begin
                s_axi_awready <= !aw_held;
            end
        end
    end

    // ------------------------------------------------
    // write data capture
    // ------------------------------------------------
    // registers are one byte wide, so only lane 0 matters
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'h0;
            w_byte <= 8'h00;
            w_lane0 <= 1'h0;
            s_axi_wready <= 1'h0;
        end else begin
            if (do_write) begin
                w_held <= 1'h0;
                s_axi_wready <= 1'h1;
            end else if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'h1;
                w_byte <= s_axi_wdata[7:0];
                w_lane0 <= s_axi_wstrb[0];
                s_axi_wready <= 1'h0;
            end else begin
                s_axi_wready <= !w_held;
            end
        end
    end

    // ------------------------------------------------
    // write response
    // ------------------------------------------------
    // unmapped indices answer slverr and change nothing
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'h0;
            s_axi_bresp <= `TARC_RESP_OKAY;
        end else begin
            if (do_write) begin
                s_axi_bvalid <= 1'h1;
                s_axi_bresp <= wr_hit ? `TARC_RESP_OKAY : `TARC_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'h0;
            end
        end
    end

    // ------------------------------------------------
    // register writes
    // ------------------------------------------------
    // upper bits of the written byte are dropped per field
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            coarse_load_cap_code <= `TARC_RST_COARSE;
            crystal_fine_trim <= `TARC_RST_FINE;
            monitor_en <= `TARC_RST_MONITOR;
            conv_sel <= `TARC_RST_CONV_SEL;
            strength_offset_comp <= `TARC_RST_OFFSET;
            strength_slope_comp <= `TARC_RST_SLOPE;
            rate_accept_pos_threshold <= `TARC_RST_RATE_POS;
            rate_limit_enable <= `TARC_RST_CLK_REC;
        end else if (do_write && w_lane0) begin
            unique case (aw_idx)
                `TARC_IDX_COARSE: begin
                    coarse_load_cap_code <= w_byte[4:0];
                end
                `TARC_IDX_FINE: begin
                    crystal_fine_trim <= w_byte[3:0];
                end
                `TARC_IDX_MONITOR: begin
                    monitor_en <= w_byte[`TARC_MON_EN_BIT];
                end
                `TARC_IDX_CONV_SEL: begin
                    conv_sel <= w_byte[2:0];
                end
                `TARC_IDX_OFFSET: begin
                    strength_offset_comp <= w_byte;
                end
                `TARC_IDX_SLOPE: begin
                    strength_slope_comp <= w_byte;
                end
                `TARC_IDX_RATE_POS: begin
                    rate_accept_pos_threshold <= w_byte;
                end
                `TARC_IDX_CLK_REC: begin
                    rate_limit_enable <= w_byte[`TARC_LIMIT_EN_BIT];
                end
                default: begin
                    // unmapped: nothing stored
                end
            endcase
        end
    end

    // ------------------------------------------------
    // read decode
    // ------------------------------------------------
    // the coarse register reads back the code as written;
    // the clamp only acts on the trim output
    always_comb begin
        next_rbyte = 8'h00;
        unique case (ar_idx)
            `TARC_IDX_COARSE: begin
                next_rbyte = {3'h0, coarse_load_cap_code};
            end
            `TARC_IDX_FINE: begin
                next_rbyte = {4'h0, crystal_fine_trim};
            end
            `TARC_IDX_MONITOR: begin
                next_rbyte = {7'h00, monitor_en};
            end
            `TARC_IDX_CONV_SEL: begin
                next_rbyte = {5'h00, conv_sel};
            end
            `TARC_IDX_OFFSET: begin
                next_rbyte = strength_offset_comp;
            end
            `TARC_IDX_SLOPE: begin
                next_rbyte = strength_slope_comp;
            end
            `TARC_IDX_RATE_POS: begin
                next_rbyte = rate_accept_pos_threshold;
            end
            `TARC_IDX_CLK_REC: begin
                next_rbyte = {7'h00, rate_limit_enable};
            end
            default: begin
                next_rbyte = 8'h00;
            end
        endcase
    end

    // ------------------------------------------------
    // read channel
    // ------------------------------------------------
    // one read at a time: the address is refused while data
    // waits, which keeps rdata stable until rready
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'h0;
            s_axi_rvalid <= 1'h0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `TARC_RESP_OKAY;
        end else begin
            if (ar_take) begin
                s_axi_arready <= 1'h0;
                s_axi_rvalid <= 1'h1;
                s_axi_rdata <= {24'h00_0000, next_rbyte};
                s_axi_rresp <= rd_hit ? `TARC_RESP_OKAY : `TARC_RESP_SLVERR;
            end else if (s_axi_rvalid) begin
                if (s_axi_rready) begin
                    s_axi_rvalid <= 1'h0;
                end
            end else begin
                s_axi_arready <= 1'h1;
            end
        end
    end

    // ------------------------------------------------
    // trim and control outputs
    // ------------------------------------------------
    // codes past the top step saturate so the load never
    // exceeds the largest switched capacitance
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trim.coarse <= `TARC_RST_COARSE;
            trim.fine <= `TARC_RST_FINE;
        end else begin
            if (coarse_load_cap_code > `TARC_COARSE_MAX) begin
                trim.coarse <= `TARC_COARSE_MAX;
            end else begin
                trim.coarse <= coarse_load_cap_code;
            end
            trim.fine <= crystal_fine_trim;
        end
    end

    // monitor buffer and converter selector follow their fields
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            strength_pin_buffer_enable <= `TARC_RST_MONITOR;
            converter_input_select <= `TARC_RST_CONV_SEL;
        end else begin
            strength_pin_buffer_enable <= monitor_en;
            converter_input_select <= conv_sel;
        end
    end

    // ------------------------------------------------
    // strength correction
    // ------------------------------------------------
    tarc_corr_s corr; // packed correction settings

    assign corr = '{offset: strength_offset_comp, slope: strength_slope_comp};

    tarc_strength_corr i_tarc_strength_corr (
        .aclk(aclk),
        .aresetn(aresetn),
        .corr(corr),
        .raw(signal_strength),
        .raw_valid(signal_strength_valid),
        .value(strength_corrected),
        .value_valid(strength_corrected_valid)
    );

    // ------------------------------------------------
    // rate acceptance
    // ------------------------------------------------
    // the threshold counts only while the limit is enabled
    tarc_rate_check i_tarc_rate_check (
        .aclk(aclk),
        .aresetn(aresetn),
        .limit_en(rate_limit_enable),
        .threshold(rate_accept_pos_threshold),
        .deviation(rate_deviation),
        .dev_valid(rate_deviation_valid),
        .accept(rate_accept),
        .accept_valid(rate_accept_valid)
    );

endmodule
`default_nettype wire

// file: tb/tarc_regs_props.sv
`timescale 1ns/10ps
`default_nettype none

module tarc_regs_props
    import tarc_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bus handshakes
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic s_axi_bvalid,
    // analogue controls
    input wire tarc_trim_s trim,
    input wire logic strength_pin_buffer_enable,
    input wire logic [2:0] converter_input_select,
    // strength and rate paths
    input wire logic signal_strength_valid,
    input wire tarc_strength_t strength_corrected,
    input wire logic strength_corrected_valid,
    input wire logic [7:0] rate_deviation,
    input wire logic rate_deviation_valid,
    input wire logic rate_accept,
    input wire logic rate_accept_valid
);
    // ----------------------------------------
    // clocking and named steps
    // ----------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // a read request taken by the slave
    sequence read_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    // the answer, with unused upper bits clear
    sequence read_answered;
        s_axi_rvalid && s_axi_rdata[31:8] == 24'h0;
    endsequence
    // any control output moved, ignoring the edge leaving reset
    sequence ctrl_moved;
        $past(aresetn) && ($changed(trim) || $changed(strength_pin_buffer_enable) || $changed(converter_input_select));
    endsequence

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    // reset must be checked while reset is low, so no disable here
    reset_state_a: assert property (disable iff (1'b0)
        !aresetn |=> trim == 9'h100 && strength_pin_buffer_enable && converter_input_select == 3'h0 && rate_accept)
        else $error("control outputs not at reset values");
    trim_clamp_a: assert property (trim.coarse <= 5'h18)
        else $error("coarse trim output above maximum");
    read_answer_a: assert property (read_taken |=> read_answered)
        else $error("read answer late or upper bits set");
    read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before rready");
    ctrl_cause_a: assert property (ctrl_moved |-> $past(s_axi_bvalid))
        else $error("control output changed without a write");
    strength_valid_a: assert property (signal_strength_valid |-> ##[1:2] strength_corrected_valid)
        else $error("corrected strength not produced");
    strength_range_a: assert property (strength_corrected_valid |-> strength_corrected >= -256 && strength_corrected <= 762)
        else $error("corrected strength out of range");
    rate_valid_a: assert property (rate_deviation_valid |-> ##[1:2] rate_accept_valid)
        else $error("rate verdict not produced");
    rate_zero_a: assert property (rate_deviation_valid && rate_deviation == 8'h00 |-> ##[1:2] rate_accept_valid && rate_accept)
        else $error("zero deviation refused");
    rate_hold_a: assert property ($past(aresetn) && !rate_accept_valid |-> $stable(rate_accept))
        else $error("rate verdict moved without a sample");
endmodule

`default_nettype wire

// file: tb/tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "tarc_cfg.svh"
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin errors++; $display("Error at %0t ns: got %h expected %h", $time, got, exp); end end

module tb
    import tarc_pkg::*;
;
    // row: index, written byte, expected read-back
    typedef logic [23:0] tarc_row_t;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, strength_pin_buffer_enable;
    logic signal_strength_valid, strength_corrected_valid, rate_deviation_valid, rate_accept, rate_accept_valid;
    logic [9:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [2:0] converter_input_select;
    logic [7:0] signal_strength, rate_deviation;
    logic [7:0] sh_c = 8'h10, sh_f = 8'h00, sh_m = 8'h01, sh_s = 8'h00; // shadow of control registers
    tarc_trim_s trim;
    tarc_strength_t strength_corrected;
    int errors = 0, comparisons = 0;
    tarc_row_t rows[17] = '{24'h8c0505, 24'h8c1919, 24'h8c1818, 24'h8cff1f, 24'h8dff0f, 24'h8d0505, 24'h8e0000,
        24'h8eff01, 24'h8efe00, 24'h8f0101, 24'h8f0202, 24'h8f0000, 24'h8fff07, 24'h900000, 24'h91ffff,
        24'h92aaaa, 24'ha0ff01};
    logic [15:0] rst_tab[8] = '{16'h8c10, 16'h8d00, 16'h8e01, 16'h8f00, 16'h9080, 16'h9180, 16'h921e, 16'ha000};
    tarc_row_t str_tab[5] = '{24'h808064, 24'h008000, 24'h8000ff, 24'h00ffff, 24'hffffff}; // offset, slope, raw
    tarc_row_t rate_tab[6] = '{24'h01aaaa, 24'h01aaab, 24'h00aaff, 24'h010000, 24'h01ffff, 24'h010001}; // en, thr, dev

    // every port of the block has a bench signal of the same name
    tarc_regs i_tarc_regs (.*);

    // ----------------------------------------
    // clock, verdict and watchdog
    // ----------------------------------------
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    task automatic print_verdict();
        $display("Comparisons: %0d, errors: %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // the whole run is a few hundred cycles; twenty thousand means a hang
    initial begin
        #800000;
        errors++;
        $display("Error at %0t ns: watchdog expired", $time);
        print_verdict();
    end

    // ----------------------------------------
    // bus and sample tasks
    // ----------------------------------------
    // write: address and data offered together, each released once taken
    task automatic axi_wr(input logic [7:0] idx, input logic [7:0] d, input logic [3:0] st, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= {24'h0, d};
        s_axi_wstrb <= st;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        `CHK(s_axi_bresp, er)
        s_axi_bready <= 1'b0;
    endtask

    // read: rready held until the answer is sampled
    task automatic axi_rd(input logic [7:0] idx, input logic [7:0] ed, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        `CHK(s_axi_rdata, {24'h0, ed})
        `CHK(s_axi_rresp, er)
        s_axi_rready <= 1'b0;
    endtask

    // controls must follow the shadow copy, coarse clamped at its maximum
    task automatic chk_out();
        `CHK(trim.coarse, (sh_c[4:0] > 5'h18) ? 5'h18 : sh_c[4:0])
        `CHK(trim.fine, sh_f[3:0])
        `CHK(strength_pin_buffer_enable, sh_m[0])
        `CHK(converter_input_select, sh_s[2:0])
    endtask

    // one pulse on a sample input; the answer is awaited for a few cycles only
    task automatic pulse(input bit rate, input logic [7:0] v);
        int n;
        @(posedge aclk);
        signal_strength <= v;
        rate_deviation <= v;
        if (rate) rate_deviation_valid <= 1'b1;
        else signal_strength_valid <= 1'b1;
        for (n = 0; n < 4; n++) begin
            @(posedge aclk);
            signal_strength_valid <= 1'b0;
            rate_deviation_valid <= 1'b0;
            #1;
            if (rate ? rate_accept_valid === 1'b1 : strength_corrected_valid === 1'b1) break;
        end
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        int i, e;
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 56'h0;
        {signal_strength, signal_strength_valid, rate_deviation, rate_deviation_valid} = 18'h0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk_out();
        // ordinary writes and read-backs, upper bits dropped
        for (i = 0; i < 17; i++) begin
            axi_wr(rows[i][23:16], rows[i][15:8], 4'hf, `TARC_RESP_OKAY);
            axi_rd(rows[i][23:16], rows[i][7:0], `TARC_RESP_OKAY);
            case (rows[i][23:16])
                `TARC_IDX_COARSE: sh_c = rows[i][7:0];
                `TARC_IDX_FINE: sh_f = rows[i][7:0];
                `TARC_IDX_MONITOR: sh_m = rows[i][7:0];
                `TARC_IDX_CONV_SEL: sh_s = rows[i][7:0];
                default: ;
            endcase
            chk_out();
        end
        // low byte not strobed: accepted, nothing stored
        axi_wr(`TARC_IDX_CONV_SEL, 8'h05, 4'he, `TARC_RESP_OKAY);
        axi_rd(`TARC_IDX_CONV_SEL, 8'h07, `TARC_RESP_OKAY);
        // unmapped neighbour index is refused both ways
        axi_wr(8'h93, 8'hff, 4'hf, `TARC_RESP_SLVERR);
        axi_rd(8'h93, 8'h00, `TARC_RESP_SLVERR);
        // correction at the corners of offset and slope
        for (i = 0; i < 5; i++) begin
            axi_wr(`TARC_IDX_OFFSET, str_tab[i][23:16], 4'hf, `TARC_RESP_OKAY);
            axi_wr(`TARC_IDX_SLOPE, str_tab[i][15:8], 4'hf, `TARC_RESP_OKAY);
            pulse(1'b0, str_tab[i][7:0]);
            e = ((int'(str_tab[i][7:0]) * int'(str_tab[i][15:8])) >> 7) + 2 * int'(str_tab[i][23:16]) - 256;
            `CHK(strength_corrected_valid, 1'b1)
            `CHK(strength_corrected, tarc_strength_t'(e))
        end
        // threshold boundary, with and without the limit enable
        for (i = 0; i < 6; i++) begin
            axi_wr(`TARC_IDX_CLK_REC, rate_tab[i][23:16], 4'hf, `TARC_RESP_OKAY);
            axi_wr(`TARC_IDX_RATE_POS, rate_tab[i][15:8], 4'hf, `TARC_RESP_OKAY);
            pulse(1'b1, rate_tab[i][7:0]);
            `CHK(rate_accept_valid, 1'b1)
            `CHK(rate_accept, !rate_tab[i][16] || rate_tab[i][7:0] <= rate_tab[i][15:8])
        end
        // second reset in mid-run restores every register
        aresetn <= 1'b0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        {sh_c, sh_f, sh_m, sh_s} = 32'h10000100;
        @(posedge aclk);
        chk_out();
        `CHK(rate_accept, 1'b1)
        for (i = 0; i < 8; i++) begin
            axi_rd(rst_tab[i][15:8], rst_tab[i][7:0], `TARC_RESP_OKAY);
        end
        print_verdict();
    end
endmodule

bind tarc_regs tarc_regs_props i_tarc_regs_props (.*);

`default_nettype wire
